// ### ssl_pkg.sv
// Package for the supply supervision logic: register map, field layout,
// reset values, filter and delay counts, modes and carried structs.
// Assumes a 20 MHz system clock and a classic Wishbone register bus.
package ssl_pkg;

   // ==========================================================
   // Clock and timing
   localparam int unsigned CLK_PERIOD_NS = 50;
   localparam int unsigned UV_FILT_NS = 50000; // Undervoltage filter time
   localparam int unsigned OV_FILT_NS = 50000; // Overvoltage filter time
   localparam int unsigned CCP_NS = 2000; // Cross-current protect time
   localparam int unsigned RD1_US = 10000; // First reset delay

   // Least time to whole cycles, never below one
   function automatic int unsigned ssl_min_cycles(input int unsigned ns);
      int unsigned cyc;
      cyc = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (cyc == 0) ? 1 : cyc;
   endfunction

   localparam int unsigned FILT_W = 16;
   localparam int unsigned RD_W = 24;
   localparam logic [FILT_W-1:0] UV_FILT_CYC = FILT_W'(ssl_min_cycles(UV_FILT_NS));
   localparam logic [FILT_W-1:0] OV_FILT_CYC = FILT_W'(ssl_min_cycles(OV_FILT_NS));
   localparam logic [FILT_W-1:0] CCP_CYC = FILT_W'(ssl_min_cycles(CCP_NS));
   localparam int unsigned RD1_CYC_DEF = ssl_min_cycles(RD1_US * 1000);

   // ==========================================================
   // Register map (byte addresses) and field positions
   localparam logic [1:0] IDX_FLAGS = 2'h0;
   localparam logic [1:0] IDX_CTRL = 2'h1;
   localparam logic [1:0] IDX_STATUS = 2'h2;
   localparam logic [3:0] ADR_FLAGS = 4'h0;
   localparam logic [3:0] ADR_CTRL = 4'h4;
   localparam logic [3:0] ADR_STATUS = 4'h8;
   localparam int unsigned CTRL_CHARGE_PUMP_ENABLE_POS = 0;
   localparam int unsigned CTRL_BREC_POS = 1;
   localparam int unsigned CTRL_OVSEL_POS = 2;
   localparam int unsigned CTRL_HBMODE_POS = 8;
   localparam int unsigned CTRL_HSOFF_POS = 16;

   // ==========================================================
   // Types
   typedef enum logic [2:0]
   {
      SSL_MODE_INIT = 3'h0,
      SSL_MODE_RESTART = 3'h1,
      SSL_MODE_NORMAL = 3'h2,
      SSL_MODE_STOP = 3'h3,
      SSL_MODE_SLEEP = 3'h4
   } ssl_mode_t;

   typedef enum logic [1:0]
   {
      SD_RUN = 2'h0,
      SD_TURNOFF = 2'h1,
      SD_CPOFF = 2'h3,
      SD_RESTART = 2'h2
   } ssl_sd_t;

   // Comparator and monitor levels from the analog side
   typedef struct packed
   {
      logic int_low;
      logic int_high1;
      logic int_high2;
      logic bridge_low;
      logic bridge_high1;
      logic bridge_high2;
      logic hs_low;
      logic hs_high;
      logic reg_ok;
      logic reg_prewarn;
      logic load_peak;
      logic cp_ok;
      logic cp_low_flag;
   } ssl_cmp_t;

   typedef struct packed
   {
      logic [3:0] hs_fault_off;
      logic [7:0] half_bridge_mode_field;
      logic ov_sel;
      logic bridge_recovery_select;
      logic charge_pump_enable;
   } ssl_ctrl_t;

   typedef struct packed
   {
      logic high_side_supply_high_flag;
      logic high_side_supply_low_flag;
      logic bridge_supply_high_flag;
      logic bridge_supply_low_flag;
      logic internal_supply_high_flag;
      logic internal_supply_low_flag;
      logic power_up;
   } ssl_flags_t;

   localparam ssl_ctrl_t CTRL_RESET = '0;
   localparam ssl_flags_t FLAGS_RESET = 7'h01;

endpackage

// ### ssl_supervisor.sv
// Supply supervision logic: filters rail comparators, latches supply flags,
// sequences bridge turn-off and charge pump shutdown, and governs recovery.
// Assumes comparator levels arrive asynchronously, the mode from same-clock
// logic, srst from the internal power-on reset, classic Wishbone software.
//
// What this block does
// - Power-on sets power-up flag and returns every register to default
// - Reset output held low until regulator good, then first reset delay
// - Internal supply below power-on threshold resets block, restarts in Init
// - Internal undervoltage monitored in Init/Restart/Normal after filter time
// - Filtered internal undervoltage suspends regulator short diagnosis only
// - Supply low/high flags latch until software clears them
// - Stop Mode: internal undervoltage off unless peak load or prewarning
// - Internal overvoltage monitored in Init/Restart/Normal after filter time
// - Fault first discharges bridges in mode 01b/10b for cross-current time
// - Charge pump off from start of bridge turn-off, passive discharge on after it
// - Recovery with pump enable 0 keeps pump and bridge off
// - Overvoltage recovery, select 0: pump restarts, bridge waits flag clear
// - Overvoltage recovery, select 1: bridge enabled once pump voltage good
// - Bridge undervoltage monitored in Init/Restart/Normal after filter
// - Bridge undervoltage recovery restarts pump, bridge waits flag clear
// - Bridge overvoltage monitored in active modes or while pump enabled
// - Bridge overvoltage recovery, select 0, needs pump enable, no pump low
// - High-side supply low disables LIN transmitter and receiver
// - High-side faults set own flag only; clear accepted after condition ends
// - High-side switches follow their configured fault response
//
// The Wishbone interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module ssl_supervisor
   import ssl_pkg::*;
#(
   parameter int unsigned RD1_CYC = RD1_CYC_DEF
)
(
   input wire logic clk,
   input wire logic srst,
   input wire ssl_cmp_t cmp_i,
   input wire ssl_mode_t mode_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   output logic reset_out_n,
   output logic sc_diag_enable_o,
   output logic [3:0] hb_discharge_o,
   output logic cp_on_o,
   output logic cp_passive_discharge_o,
   output logic bridge_enable_o,
   output logic lin_enable_o,
   output logic [3:0] hs_fault_off_o
);

   // ==========================================================
   // State
   typedef struct packed
   {
      ssl_cmp_t s1;
      ssl_cmp_t s2;
      logic [3:0][FILT_W-1:0] filt;
      ssl_flags_t flags;
      ssl_ctrl_t ctrl;
      ssl_sd_t sd;
      logic [FILT_W-1:0] ccp_cnt;
      logic [3:0] hb_sel;
      logic cause_ov;
      logic cause_bov;
      logic cause_uv;
      logic rst_n;
      logic [RD_W-1:0] rd_cnt;
      logic ack;
      logic [31:0] dat;
   } ssl_state_t;

   ssl_state_t q;
   ssl_state_t d;
   ssl_cmp_t c;
   logic [3:0] raw;
   logic [3:0] hit;
   logic mon_on;
   logic int_uv_on;
   logic bov_on;
   logic fault;
   logic req;
   ssl_flags_t clr;
   logic restart_ok;
   logic run_ok;

   // Filter step: count consecutive comparator cycles, saturate at limit
   function automatic logic [FILT_W-1:0] ssl_filt_step(input logic [FILT_W-1:0] cnt,
                                                        input logic cmp,
                                                        input logic [FILT_W-1:0] lim);
      if (!cmp)
      begin
         return '0;
      end
      return (cnt == lim) ? cnt : cnt + 1'b1;
   endfunction

   // Bridges whose mode field asks for the static discharge
   function automatic logic [3:0] ssl_hb_pick(input logic [7:0] modes);
      logic [3:0] sel;
      sel = '0;
      for (int i = 0; i < 4; i++)
      begin
         sel[i] = (modes[2*i +: 2] == 2'b01) || (modes[2*i +: 2] == 2'b10);
      end
      return sel;
   endfunction

   // ==========================================================
   // Monitor enables and comparator filtering
   always_comb
   begin
      c = q.s2;
      mon_on = (mode_i == SSL_MODE_INIT) || (mode_i == SSL_MODE_RESTART) ||
               (mode_i == SSL_MODE_NORMAL);
      int_uv_on = mon_on || ((mode_i == SSL_MODE_STOP) && (c.load_peak || c.reg_prewarn));
      bov_on = mon_on || q.ctrl.charge_pump_enable;
      raw[0] = c.int_low && int_uv_on;
      raw[1] = (q.ctrl.ov_sel ? c.int_high2 : c.int_high1) && mon_on;
      raw[2] = c.bridge_low && mon_on;
      raw[3] = (q.ctrl.ov_sel ? c.bridge_high2 : c.bridge_high1) && bov_on;
      for (int i = 0; i < 4; i++)
      begin
         hit[i] = (q.filt[i] == ((i % 2 == 1) ? OV_FILT_CYC : UV_FILT_CYC));
      end
      fault = hit[1] || hit[2] || hit[3];
      req = wb_cyc_i && wb_stb_i && !q.ack;
      clr = '0;
      if (req && wb_we_i && (wb_adr_i[3:2] == IDX_FLAGS) && wb_sel_i[0])
      begin
         clr = ssl_flags_t'(wb_dat_i[6:0]);
      end
      restart_ok = !fault && q.ctrl.charge_pump_enable &&
                   (!q.cause_bov || q.ctrl.bridge_recovery_select || !c.cp_low_flag);
      run_ok = (!q.cause_ov || (q.ctrl.bridge_recovery_select ? c.cp_ok :
                 (!q.flags.internal_supply_high_flag && !q.flags.bridge_supply_high_flag))) &&
               (!q.cause_uv || !q.flags.bridge_supply_low_flag);
   end

   // ==========================================================
   // Next state
   always_comb
   begin
      d = q;
      d.s1 = cmp_i;
      d.s2 = q.s1;
      for (int i = 0; i < 4; i++)
      begin
         d.filt[i] = ssl_filt_step(q.filt[i], raw[i],
                                   (i % 2 == 1) ? OV_FILT_CYC : UV_FILT_CYC);
      end

      d.flags.internal_supply_low_flag = hit[0] ||
         (q.flags.internal_supply_low_flag && !clr.internal_supply_low_flag);
      d.flags.internal_supply_high_flag = hit[1] ||
         (q.flags.internal_supply_high_flag && !clr.internal_supply_high_flag);
      d.flags.bridge_supply_low_flag = hit[2] ||
         (q.flags.bridge_supply_low_flag && !clr.bridge_supply_low_flag);
      d.flags.bridge_supply_high_flag = hit[3] ||
         (q.flags.bridge_supply_high_flag && !clr.bridge_supply_high_flag);
      d.flags.high_side_supply_low_flag = c.hs_low ||
         (q.flags.high_side_supply_low_flag && !clr.high_side_supply_low_flag);
      d.flags.high_side_supply_high_flag = c.hs_high ||
         (q.flags.high_side_supply_high_flag && !clr.high_side_supply_high_flag);
      d.flags.power_up = q.flags.power_up && !clr.power_up;

      // Bus slave: one wait state, unmapped reads give zero
      d.ack = req;
      if (req)
      begin
         d.dat = '0;
         unique case (wb_adr_i[3:2])
            IDX_FLAGS:
            begin
               d.dat[6:0] = q.flags;
            end
            IDX_CTRL:
            begin
               d.dat[CTRL_CHARGE_PUMP_ENABLE_POS] = q.ctrl.charge_pump_enable;
               d.dat[CTRL_BREC_POS] = q.ctrl.bridge_recovery_select;
               d.dat[CTRL_OVSEL_POS] = q.ctrl.ov_sel;
               d.dat[CTRL_HBMODE_POS +: 8] = q.ctrl.half_bridge_mode_field;
               d.dat[CTRL_HSOFF_POS +: 4] = q.ctrl.hs_fault_off;
               if (wb_we_i && wb_sel_i[0])
               begin
                  d.ctrl.charge_pump_enable = wb_dat_i[CTRL_CHARGE_PUMP_ENABLE_POS];
                  d.ctrl.bridge_recovery_select = wb_dat_i[CTRL_BREC_POS];
                  d.ctrl.ov_sel = wb_dat_i[CTRL_OVSEL_POS];
               end
               if (wb_we_i && wb_sel_i[1])
               begin
                  d.ctrl.half_bridge_mode_field = wb_dat_i[CTRL_HBMODE_POS +: 8];
               end
               if (wb_we_i && wb_sel_i[2])
               begin
                  d.ctrl.hs_fault_off = wb_dat_i[CTRL_HSOFF_POS +: 4];
               end
            end
            IDX_STATUS:
            begin
               d.dat[1:0] = q.sd;
               d.dat[2] = q.rst_n;
               d.dat[3] = !hit[0];
               d.dat[7:4] = hb_discharge_o;
               d.dat[8] = cp_on_o;
               d.dat[9] = bridge_enable_o;
               d.dat[10] = lin_enable_o;
            end
            default:
            begin
               d.dat = '0;
            end
         endcase
      end

      // Shutdown and recovery sequence
      unique case (q.sd)
         SD_RUN:
         begin
            if (fault)
            begin
               d.sd = SD_TURNOFF;
               d.hb_sel = ssl_hb_pick(q.ctrl.half_bridge_mode_field);
               d.ccp_cnt = '0;
            end
         end
         SD_TURNOFF:
         begin
            d.ccp_cnt = q.ccp_cnt + 1'b1;
            if (q.ccp_cnt == CCP_CYC - 1'b1)
            begin
               d.sd = SD_CPOFF;
            end
         end
         SD_CPOFF:
         begin
            if (restart_ok)
            begin
               d.sd = SD_RESTART;
            end
         end
         SD_RESTART:
         begin
            if (fault)
            begin
               d.sd = SD_TURNOFF;
               d.hb_sel = ssl_hb_pick(q.ctrl.half_bridge_mode_field);
               d.ccp_cnt = '0;
            end
            else if (!q.ctrl.charge_pump_enable)
            begin
               d.sd = SD_CPOFF;
            end
            else if (run_ok)
            begin
               d.sd = SD_RUN;
            end
         end
      endcase
      // Remember what caused the shutdown until the bridge runs again
      if (d.sd == SD_RUN)
      begin
         d.cause_ov = 1'b0;
         d.cause_bov = 1'b0;
         d.cause_uv = 1'b0;
      end
      else
      begin
         d.cause_ov = q.cause_ov || hit[1] || hit[3];
         d.cause_bov = q.cause_bov || hit[3];
         d.cause_uv = q.cause_uv || hit[2];
      end

      // reset held until regulator good plus delay
      if (!c.reg_ok)
      begin
         d.rst_n = 1'b0;
         d.rd_cnt = '0;
      end
      else if (!q.rst_n)
      begin
         d.rd_cnt = q.rd_cnt + 1'b1;
         d.rst_n = (q.rd_cnt == RD_W'(RD1_CYC - 1));
      end
   end

   // ==========================================================
   // Registers
   // power-on defaults and power-up flag
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         q <= '0;
         q.flags <= FLAGS_RESET;
         q.ctrl <= CTRL_RESET;
         q.sd <= SD_RUN;
      end
      else
      begin
         q <= d;
      end
   end

   // ==========================================================
   // Outputs
   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.dat;
   assign reset_out_n = q.rst_n;
   // short diagnosis paused during filtered low supply
   assign sc_diag_enable_o = !hit[0];
   assign hb_discharge_o = (q.sd == SD_TURNOFF) ? q.hb_sel : 4'h0;
   assign cp_on_o = q.ctrl.charge_pump_enable && ((q.sd == SD_RUN) || (q.sd == SD_RESTART));
   assign cp_passive_discharge_o = (q.sd == SD_CPOFF);
   assign bridge_enable_o = (q.sd == SD_RUN) && q.ctrl.charge_pump_enable;
   // LIN off while high-side rail low
   assign lin_enable_o = !q.s2.hs_low;
   assign hs_fault_off_o = q.ctrl.hs_fault_off & {4{q.s2.hs_low || q.s2.hs_high}};

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   flag_latch_a: assert property (q.flags.bridge_supply_low_flag && !clr.bridge_supply_low_flag |=> q.flags.bridge_supply_low_flag) else $error("bridge low flag lost");
   uv_filter_a: assert property ($rose(q.flags.internal_supply_low_flag) |-> $past(q.filt[0]) == UV_FILT_CYC) else $error("low flag before filter time");
   filt_restart_a: assert property (!raw[3] |=> q.filt[3] == '0) else $error("filter not restarted");
   stop_mon_a: assert property (mode_i == SSL_MODE_STOP && !c.load_peak && !c.reg_prewarn |=> q.filt[0] == '0) else $error("stop mode low watch active");
   turnoff_hold_a: assert property (q.sd == SD_TURNOFF && q.ccp_cnt < CCP_CYC - 1'b1 |=> q.sd == SD_TURNOFF && hb_discharge_o == $past(q.hb_sel)) else $error("discharge cut short");
   cp_order_a: assert property (q.sd == SD_CPOFF && $past(q.sd) != SD_CPOFF |-> $past(q.sd) == SD_TURNOFF && !cp_on_o && cp_passive_discharge_o) else $error("pump off out of order");
   charge_pump_enable_off_a: assert property (q.sd == SD_CPOFF && !q.ctrl.charge_pump_enable |=> !cp_on_o && !bridge_enable_o) else $error("pump or bridge on without enable");
   ov_hold_a: assert property (q.sd == SD_RESTART && q.cause_ov && !q.ctrl.bridge_recovery_select && q.flags.internal_supply_high_flag |=> q.sd != SD_RUN) else $error("bridge on with flag set");
   brec_on_a: assert property (q.sd == SD_RESTART && !fault && q.cause_ov && !q.cause_uv && q.ctrl.bridge_recovery_select && q.ctrl.charge_pump_enable && c.cp_ok |=> bridge_enable_o) else $error("bridge not enabled");
   uv_hold_a: assert property (q.sd == SD_RESTART && q.cause_uv && q.flags.bridge_supply_low_flag |=> q.sd != SD_RUN) else $error("bridge on with low flag");
   reset_hold_a: assert property (!c.reg_ok |=> !reset_out_n) else $error("reset released early");
   lin_off_a: assert property (q.s2.hs_low |-> !lin_enable_o ##1 q.flags.high_side_supply_low_flag) else $error("LIN active on low rail");
   hs_clear_a: assert property (q.s2.hs_high |=> q.flags.high_side_supply_high_flag) else $error("high-side flag cleared early");
   sc_diag_a: assert property (hit[0] |-> !sc_diag_enable_o) else $error("diagnosis active in low supply");

   shutdown_c: cover property (q.sd == SD_TURNOFF ##[1:100] q.sd == SD_CPOFF);
   recover_c: cover property (q.sd == SD_RESTART ##1 q.sd == SD_RUN);
   release_c: cover property ($rose(reset_out_n));
   clear_c: cover property (q.flags.bridge_supply_high_flag ##1 !q.flags.bridge_supply_high_flag);
   // Stop Mode low watch reaching its filter limit, whether peak load or prewarning woke it
   stop_peak_c: cover property (mode_i == SSL_MODE_STOP && hit[0]);

endmodule

`default_nettype wire

// ### ssl_mcu_model.sv
// Microcontroller model: classic Wishbone master that reads and clears flags.
// Assumes one clock shared with the supervisor; bench calls its tasks.
`timescale 1ns/1ps
`default_nettype none

module ssl_mcu_model
   import ssl_pkg::*;
(
   input wire logic clk,
   output logic wb_cyc,
   output logic wb_stb,
   output logic wb_we,
   output logic [3:0] wb_adr,
   output logic [3:0] wb_sel,
   output logic [31:0] wb_dat,
   input wire logic [31:0] wb_rdat,
   input wire logic wb_ack
);
   // ==========================================
   // Bus cycle
   initial
   begin
      wb_cyc = 1'b0;
      wb_stb = 1'b0;
      wb_we = 1'b0;
      wb_adr = 4'h0;
      wb_sel = 4'h0;
      wb_dat = 32'h0;
   end

   // One request, held until ack is sampled high, then released
   task automatic xfer(input logic we, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
      @(posedge clk);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_sel <= 4'hF;
      wb_dat <= d;
      @(posedge clk);
      while (wb_ack !== 1'b1)
         @(posedge clk);
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_dat <= ~d; // Released data does not linger
   endtask
endmodule
`default_nettype wire

// ### ssl_supervisor_bench.sv
// Self-checking bench for the supply supervisor.
// Assumes the supervisor, its package and the microcontroller model.
`timescale 1ns/1ps
`default_nettype none

module ssl_supervisor_bench;
   import ssl_pkg::*;
   localparam int RD1 = 20;
   logic clk, srst;
   ssl_cmp_t cmp;
   ssl_mode_t mode;
   logic cyc, stb, we, ack, rst_n, diag, cp_on, cp_pd, br_en, lin_en;
   logic [3:0] adr, sel, hb_dis, hs_off;
   logic [31:0] wdat, rdat;
   int fails, checks;

   // ==========================================
   // Clock, instances
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   ssl_mcu_model mcu (.clk(clk), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we), .wb_adr(adr),
      .wb_sel(sel), .wb_dat(wdat), .wb_rdat(rdat), .wb_ack(ack));

   ssl_supervisor #(.RD1_CYC(RD1)) dut (.clk(clk), .srst(srst), .cmp_i(cmp), .mode_i(mode),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .reset_out_n(rst_n),
      .sc_diag_enable_o(diag), .hb_discharge_o(hb_dis), .cp_on_o(cp_on),
      .cp_passive_discharge_o(cp_pd), .bridge_enable_o(br_en), .lin_enable_o(lin_en),
      .hs_fault_off_o(hs_off));

   // ==========================================
   // Helpers
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [31:0] q;
      mcu.xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input string n, input logic [3:0] a, input logic [31:0] e);
      logic [31:0] q;
      mcu.xfer(1'b0, a, 32'h0, q);
      chk(n, e, q);
   endtask

   task automatic cyc_n(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic stop_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // ==========================================
   // Scenarios
   task automatic t_power_up();
      rd("flags", ADR_FLAGS, 32'(FLAGS_RESET));
      rd("ctrl", ADR_CTRL, 32'h0);
      rd("unmapped", 4'hC, 32'h0);
      wr(ADR_FLAGS, 32'h1);
      chk("rst_n held", 1'b0, rst_n);
      cmp.reg_ok <= 1'b1;
      cyc_n(RD1);
      chk("rst_n delay", 1'b0, rst_n);
      cyc_n(5);
      chk("rst_n free", 1'b1, rst_n);
   endtask

   task automatic t_int_uv();
      cmp.int_low <= 1'b1;
      cyc_n(900);
      cmp.int_low <= 1'b0;
      cyc_n(10);
      cmp.int_low <= 1'b1;
      cyc_n(900);
      chk("diag early", 1'b1, diag);
      cyc_n(110);
      chk("diag off", 1'b0, diag);
      cmp.int_low <= 1'b0;
      cyc_n(5);
      chk("diag back", 1'b1, diag);
      rd("uv latched", ADR_FLAGS, 32'h2);
      wr(ADR_FLAGS, 32'h2);
      rd("uv clear", ADR_FLAGS, 32'h0);
   endtask

   // Bridge overvoltage, recovery select 0
   task automatic t_bridge_ov();
      cmp.cp_ok <= 1'b1;
      wr(ADR_CTRL, 32'h9C01);
      cmp.bridge_high1 <= 1'b1;
      cyc_n(1010);
      chk("discharge", 4'hC, hb_dis);
      cyc_n(int'(CCP_CYC));
      chk("discharge end", 4'h0, hb_dis);
      chk("cp off", 1'b0, cp_on);
      chk("passive", 1'b1, cp_pd);
      rd("status cpoff", ADR_STATUS, 32'h40F);
      cmp.bridge_high1 <= 1'b0;
      cyc_n(10);
      chk("cp again", 1'b1, cp_on);
      chk("bridge waits", 1'b0, br_en);
      rd("ov flag", ADR_FLAGS, 32'h10);
      wr(ADR_FLAGS, 32'h10);
      cyc_n(3);
      chk("bridge on", 1'b1, br_en);
   endtask

   // Internal overvoltage, recovery select 1 then pump disabled
   task automatic t_int_ov(input logic brec);
      wr(ADR_CTRL, {16'h0, 8'h9C, 6'h0, brec, brec});
      cmp.cp_ok <= 1'b0;
      cmp.int_high1 <= 1'b1;
      cyc_n(1060);
      cmp.int_high1 <= 1'b0;
      cyc_n(10);
      chk("cp restart", brec, cp_on);
      chk("bridge off", 1'b0, br_en);
      cmp.cp_ok <= 1'b1;
      cyc_n(5);
      chk("bridge pump ok", brec, br_en);
      rd("int ov flag", ADR_FLAGS, 32'h4);
      wr(ADR_FLAGS, 32'h4);
   endtask

   task automatic t_high_side(input int bitn);
      wr(ADR_CTRL, 32'h50000);
      if (bitn == 5)
         cmp.hs_low <= 1'b1;
      else
         cmp.hs_high <= 1'b1;
      cyc_n(4);
      chk("lin", (bitn == 6), lin_en);
      chk("hs response", 4'h5, hs_off);
      wr(ADR_FLAGS, 32'(1 << bitn));
      rd("hs only", ADR_FLAGS, 32'(1 << bitn));
      cmp.hs_low <= 1'b0;
      cmp.hs_high <= 1'b0;
      cyc_n(4);
      wr(ADR_FLAGS, 32'(1 << bitn));
      rd("hs clear", ADR_FLAGS, 32'h0);
   endtask

   task automatic t_stop();
      mode <= SSL_MODE_STOP;
      cmp.int_low <= 1'b1;
      cyc_n(1020);
      rd("stop quiet", ADR_FLAGS, 32'h0);
      cmp.load_peak <= 1'b1;
      cyc_n(1020);
      rd("stop peak", ADR_FLAGS, 32'h2);
      cmp.int_low <= 1'b0;
      cmp.load_peak <= 1'b0;
   endtask

   // ==========================================
   // Main sequence and watchdog
   initial
   begin
      fails = 0;
      checks = 0;
      srst = 1'b1;
      cmp = '0;
      mode = SSL_MODE_NORMAL;
      cyc_n(20);
      srst <= 1'b0;
      t_power_up();
      t_int_uv();
      t_bridge_ov();
      t_int_ov(1'b1);
      t_int_ov(1'b0);
      t_high_side(5);
      t_high_side(6);
      t_stop();
      stop_test();
   end

   initial
   begin
      #1500000;
      fails++;
      stop_test();
   end
endmodule
`default_nettype wire
